//--- ifo_defs.svh
// Purpose: Constants of the input force override block
// Assumes: 10 MHz reference clock
// Notes: Offsets are byte addresses on the plain register port
`ifndef IFO_DEFS_SVH
`define IFO_DEFS_SVH

`define IFO_NUM_IN 16
`define IFO_NUM_OUT 32
`define IFO_RPT_W 16
`define IFO_SYNC_W 17
`define IFO_TMR_W 17
`define IFO_TO_W 16
`define IFO_ADDR_W 8
`define IFO_DATA_W 32

`define IFO_CLK_PERIOD_NS 100
`define IFO_TICK_NS 500000000
`define IFO_TICK_CYCLES (`IFO_TICK_NS / `IFO_CLK_PERIOD_NS)
`define IFO_TICK_CNT_W 23
`define IFO_TICKS_PER_S (1000000000 / `IFO_TICK_NS)
`define IFO_ERR_TIMEOUT_S 30
`define IFO_ERR_TICKS (`IFO_ERR_TIMEOUT_S * `IFO_TICKS_PER_S)

`define IFO_REG_CMD 8'h00
`define IFO_REG_TIMEOUT 8'h04
`define IFO_REG_OVERRIDE 8'h08
`define IFO_REG_STATUS 8'h0c
`define IFO_REG_REMAIN 8'h10
`define IFO_REG_REAL_IN 8'h14

`define IFO_CMD_ENTER 0
`define IFO_CMD_EXIT 1
`define IFO_CMD_KEEPALIVE 2
`define IFO_CMD_LOGOUT 3
`define IFO_CMD_UPLOAD 4
`define IFO_CMD_STOP 5

`define IFO_STS_REFUSED_LSB 4
`define IFO_TIMEOUT_RST 16'h003c

`endif

//--- ifo_pkg.sv
// Purpose: Types of the input force override block
// Assumes: ifo_defs.svh supplies widths
// Notes: Types only, no constants
`include "ifo_defs.svh"
package ifo_pkg;

  typedef enum logic [1:0] {
    IFO_OVR_RELEASED = 2'b00,
    IFO_OVR_FORCE_LO = 2'b01,
    IFO_OVR_FORCE_HI = 2'b10,
    IFO_OVR_RSVD = 2'b11
  } ifo_ovr_e;

  typedef enum logic [1:0] {
    IFO_PH_IDLE = 2'b00,
    IFO_PH_ACTIVE = 2'b01,
    IFO_PH_SHUTDOWN = 2'b10
  } ifo_phase_e;

  typedef enum logic [1:0] {
    IFO_END_NONE = 2'b00,
    IFO_END_MANUAL = 2'b01,
    IFO_END_TIMEOUT = 2'b10,
    IFO_END_ERROR = 2'b11
  } ifo_end_e;

  typedef struct packed {
    logic logout;
    logic upload;
    logic stop;
  } ifo_host_cmd_s;

  typedef struct packed {
    logic valid;
    logic group;
    logic [`IFO_RPT_W-1:0] data;
  } ifo_report_s;

  typedef struct packed {
    logic [`IFO_SYNC_W-1:0] s1;
    logic [`IFO_SYNC_W-1:0] s2;
    logic [`IFO_SYNC_W-1:0] s3;
    logic [`IFO_SYNC_W-1:0] filt;
  } ifo_sync_state_s;

  typedef struct packed {
    logic [`IFO_TMR_W-1:0] cnt;
    logic expired;
  } ifo_tmr_state_s;

  typedef struct packed {
    ifo_phase_e phase;
    ifo_end_e end_cause;
    ifo_ovr_e [`IFO_NUM_IN-1:0] ovr;
    logic [`IFO_NUM_IN-1:0] logic_in;
    logic [3:0] refused;
    logic [`IFO_TO_W-1:0] timeout_s;
    logic [`IFO_TICK_CNT_W-1:0] tick_cnt;
    logic tick;
    logic led;
    logic err_prev;
    logic [`IFO_NUM_OUT-1:0] reported;
    logic [`IFO_NUM_OUT-1:0] gw_out;
    ifo_report_s report;
    ifo_host_cmd_s host_cmd;
    logic [`IFO_DATA_W-1:0] rdata;
  } ifo_state_s;

endpackage : ifo_pkg

//--- ifo_in_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to ref_clk_in
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps
`include "ifo_defs.svh"
module ifo_in_sync (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Raw levels
  input wire logic [`IFO_SYNC_W-1:0] raw_in,
  // Filtered levels
  output logic [`IFO_SYNC_W-1:0] level_out
);
  import ifo_pkg::*;

  ifo_sync_state_s st_ff;
  ifo_sync_state_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = raw_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // Only later stages are compared, stage one may be metastable
    for (int i = 0; i < `IFO_SYNC_W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.filt[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_out = st_ff.filt;

endmodule : ifo_in_sync

//--- ifo_tick_timer.sv
// Purpose: Down counter in whole ticks with expiry pulse
// Assumes: tick_in is a one-cycle pulse
// Notes: Clear beats load, load beats counting
`timescale 1ns/1ps
`include "ifo_defs.svh"
module ifo_tick_timer (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic tick_in,
  input wire logic clear_in,
  input wire logic load_in,
  input wire logic [`IFO_TMR_W-1:0] load_val_in,
  // Status
  output logic [`IFO_TMR_W-1:0] remain_out,
  output logic expired_out
);
  import ifo_pkg::*;

  ifo_tmr_state_s st_ff;
  ifo_tmr_state_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.expired = 1'b0;
    if (clear_in) begin
      nxt_st.cnt = '0;
    end else if (load_in) begin
      nxt_st.cnt = load_val_in;
    end else if (tick_in && st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - `IFO_TMR_W'(1);
      nxt_st.expired = (st_ff.cnt == `IFO_TMR_W'(1));
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign remain_out = st_ff.cnt;
  assign expired_out = st_ff.expired;

endmodule : ifo_tick_timer

//--- ifo_force_ctrl.sv
// Purpose: Input force override session of the safety controller main module
// Assumes: Status levels come from logic on ref_clk_in; pins and link error are asynchronous
// Notes: Timers count half-second ticks; the tick period is a parameter for simulation
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "ifo_defs.svh"

//Contract
//RULE1: A forced-low input is seen as 0 by the logic program.
//RULE2: A forced-high input is seen as 1 by the logic program.
//RULE3: A released input returns to its real physical level.
//RULE4: One override vector feeds every use of that input in the program.
//RULE5: Only program inputs are overridden; outputs and results are never forced.
//RULE6: Direct hardware paths keep real physical input levels.
//RULE7: Force mode is entered only by an authorized logged-in client.
//RULE8: Entry refused while configuration verified; unverified indicator flashes at 1 Hz.
//RULE9: Operator puts the controller in run state before asking for force mode.
//RULE10: Timeout given at entry; force mode ends when it lapses idle.
//RULE11: Every operator action reloads the inactivity timer to its full value.
//RULE12: A detected error ends force mode 30 seconds later.
//RULE13: Any end of force mode zeroes all outputs and stops the application.
//RULE14: Operator warns 15 seconds before expiry; acknowledge restarts the timer.
//RULE15: Logout, upload or compare, and stop are refused during force mode.
//RULE16: Gateway image carries only real physical input and output levels.
//RULE17: Over 16 output changes at once are reported over later cycles.
//RULE18: Force mode should be run from one computer at a time.
//RULE19: Each input holds a two-bit override state, cleared when force mode ends.
//RULE20: Timeouts count whole ticks of a fixed base from the clock.
module ifo_force_ctrl #(
  parameter int TICK_CYCLES = `IFO_TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [`IFO_ADDR_W-1:0] reg_addr_in,
  input wire logic [`IFO_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`IFO_DATA_W-1:0] reg_rdata_out,
  // Controller status
  input wire logic client_auth_in,
  input wire logic cfg_verified_in,
  input wire logic run_state_in,
  // Pins and link
  input wire logic [`IFO_NUM_IN-1:0] phys_in_in,
  input wire logic link_error_in,
  // Logic program side
  input wire logic [`IFO_NUM_OUT-1:0] outputs_in,
  input wire logic logic_cycle_in,
  output logic [`IFO_NUM_IN-1:0] logic_in_out,
  output ifo_pkg::ifo_report_s report_out,
  // Gateway and direct paths
  output logic [`IFO_NUM_IN-1:0] real_in_out,
  output logic [`IFO_NUM_OUT-1:0] gw_out_out,
  // Session results
  output logic force_active_out,
  output logic outputs_zero_out,
  output logic app_stop_out,
  output logic config_verified_indicator_out,
  output ifo_pkg::ifo_host_cmd_s host_cmd_out
);
  import ifo_pkg::*;

  ifo_state_s st_ff;
  ifo_state_s nxt_st;

  logic [`IFO_SYNC_W-1:0] sync_level;
  logic [`IFO_NUM_IN-1:0] real_in;
  logic link_err;
  logic inact_clear;
  logic inact_load;
  logic [`IFO_TMR_W-1:0] inact_load_val;
  logic [`IFO_TMR_W-1:0] inact_remain;
  logic inact_expired;
  logic err_clear;
  logic err_load;
  logic [`IFO_TMR_W-1:0] err_remain;
  logic err_expired;

  // Selects what the program sees for one input
  function automatic logic apply_override(input ifo_ovr_e ovr, input logic phys);
    logic val;
    case (ovr)
      IFO_OVR_FORCE_LO: val = 1'b0; // RULE1
      IFO_OVR_FORCE_HI: val = 1'b1; // RULE2
      IFO_OVR_RELEASED: val = phys; // RULE3
      default: val = phys;
    endcase
    return val;
  endfunction : apply_override

  function automatic logic is_reg(input logic [`IFO_ADDR_W-1:0] addr, input logic [`IFO_ADDR_W-1:0] offs);
    return addr == offs;
  endfunction : is_reg

  ifo_in_sync u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .raw_in({link_error_in, phys_in_in}),
    .level_out(sync_level)
  );

  assign real_in = sync_level[`IFO_NUM_IN-1:0];
  assign link_err = sync_level[`IFO_SYNC_W-1];

  ifo_tick_timer u_inact_tmr (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(st_ff.tick),
    .clear_in(inact_clear),
    .load_in(inact_load),
    .load_val_in(inact_load_val),
    .remain_out(inact_remain),
    .expired_out(inact_expired)
  );

  ifo_tick_timer u_err_tmr (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(st_ff.tick),
    .clear_in(err_clear),
    .load_in(err_load),
    .load_val_in(`IFO_TMR_W'(`IFO_ERR_TICKS)),
    .remain_out(err_remain),
    .expired_out(err_expired)
  );

  always_comb begin
    logic wr_cmd;
    logic [`IFO_TO_W-1:0] to_s;
    logic active;
    logic enter_ok;
    logic do_end;
    logic action;
    logic [`IFO_NUM_OUT-1:0] diff;
    wr_cmd = reg_wr_in && is_reg(reg_addr_in, `IFO_REG_CMD);
    to_s = '0;
    active = (st_ff.phase == IFO_PH_ACTIVE);
    enter_ok = 1'b0;
    do_end = 1'b0;
    action = 1'b0;
    diff = '0;
    nxt_st = st_ff;
    inact_clear = 1'b0;
    inact_load = 1'b0;
    err_clear = 1'b0;
    err_load = 1'b0;
    nxt_st.report.valid = 1'b0;
    nxt_st.host_cmd = '0;

    // Time base, half-second ticks drive both timers and the indicator
    nxt_st.tick = 1'b0;
    if (st_ff.tick_cnt == `IFO_TICK_CNT_W'(TICK_CYCLES - 1)) begin // RULE20
      nxt_st.tick_cnt = '0;
      nxt_st.tick = 1'b1;
      nxt_st.led = ~st_ff.led; // RULE8
    end else begin
      nxt_st.tick_cnt = st_ff.tick_cnt + `IFO_TICK_CNT_W'(1);
    end

    // Inactivity timeout, kept for the next entry
    if (reg_wr_in && is_reg(reg_addr_in, `IFO_REG_TIMEOUT)) begin
      nxt_st.timeout_s = reg_wdata_in[`IFO_TO_W-1:0];
    end
    to_s = (st_ff.timeout_s == '0) ? `IFO_TO_W'(1) : st_ff.timeout_s;
    inact_load_val = `IFO_TMR_W'(to_s * `IFO_TICKS_PER_S); // RULE10

    // Session state machine
    case (st_ff.phase)
      IFO_PH_IDLE: begin
        if (wr_cmd && reg_wdata_in[`IFO_CMD_ENTER]) begin
          // Run state is checked too, a stopped controller has nothing to force
          enter_ok = client_auth_in && !cfg_verified_in && run_state_in; // RULE7 RULE8 RULE9
          if (enter_ok) begin
            nxt_st.phase = IFO_PH_ACTIVE;
            nxt_st.end_cause = IFO_END_NONE;
            inact_load = 1'b1; // RULE10
          end else begin
            nxt_st.refused[0] = 1'b1;
          end
        end
      end
      IFO_PH_ACTIVE: begin
        if (wr_cmd && reg_wdata_in[`IFO_CMD_EXIT]) begin
          do_end = 1'b1;
          nxt_st.end_cause = IFO_END_MANUAL;
        end else if (err_expired) begin
          do_end = 1'b1;
          nxt_st.end_cause = IFO_END_ERROR; // RULE12
        end else if (inact_expired) begin
          do_end = 1'b1;
          nxt_st.end_cause = IFO_END_TIMEOUT; // RULE10
        end
        if (do_end) begin
          nxt_st.phase = IFO_PH_SHUTDOWN; // RULE13
        end
      end
      IFO_PH_SHUTDOWN: begin
        // Held until the application has really stopped
        if (!run_state_in) begin
          nxt_st.phase = IFO_PH_IDLE;
        end
      end
      default: begin
        nxt_st.phase = IFO_PH_IDLE;
      end
    endcase

    // Operator actions while active
    if (active && !do_end) begin
      if (wr_cmd && reg_wdata_in[`IFO_CMD_KEEPALIVE]) begin
        action = 1'b1;
      end
      if (reg_wr_in && is_reg(reg_addr_in, `IFO_REG_OVERRIDE)) begin
        action = 1'b1;
        for (int i = 0; i < `IFO_NUM_IN; i++) begin
          nxt_st.ovr[i] = ifo_ovr_e'(reg_wdata_in[2*i +: 2]); // RULE19
        end
      end
      inact_load = action; // RULE11
    end
    if (do_end || st_ff.phase != IFO_PH_ACTIVE) begin
      nxt_st.ovr = '0; // RULE19
      inact_clear = !enter_ok;
    end

    // Error detection arms the fixed timeout once per error
    nxt_st.err_prev = link_err;
    err_clear = !active;
    err_load = active && link_err && !st_ff.err_prev; // RULE12

    // Commands that would break the session are refused
    if (wr_cmd) begin
      if (reg_wdata_in[`IFO_CMD_LOGOUT]) begin
        if (active) begin
          nxt_st.refused[1] = 1'b1; // RULE15
        end else begin
          nxt_st.host_cmd.logout = 1'b1;
        end
      end
      if (reg_wdata_in[`IFO_CMD_UPLOAD]) begin
        if (active) begin
          nxt_st.refused[2] = 1'b1; // RULE15
        end else begin
          nxt_st.host_cmd.upload = 1'b1;
        end
      end
      if (reg_wdata_in[`IFO_CMD_STOP]) begin
        if (active) begin
          nxt_st.refused[3] = 1'b1; // RULE15
        end else begin
          nxt_st.host_cmd.stop = 1'b1;
        end
      end
    end

    // Refusal flags clear on write-one, which beats a new refusal of an already set flag in that cycle
    if (reg_wr_in && is_reg(reg_addr_in, `IFO_REG_STATUS)) begin
      nxt_st.refused = (st_ff.refused & ~reg_wdata_in[`IFO_STS_REFUSED_LSB +: 4]) | (nxt_st.refused & ~st_ff.refused);
    end

    // Program inputs, one vector used everywhere in the program
    for (int i = 0; i < `IFO_NUM_IN; i++) begin
      nxt_st.logic_in[i] = apply_override(st_ff.ovr[i], real_in[i]); // RULE4 RULE5
    end

    // Gateway shows real outputs, zero while the session is in shutdown
    nxt_st.gw_out = (st_ff.phase == IFO_PH_SHUTDOWN) ? '0 : outputs_in; // RULE16

    // Change reporting carries at most one group of outputs per logic cycle
    diff = outputs_in ^ st_ff.reported;
    if (logic_cycle_in) begin
      if (diff[`IFO_RPT_W-1:0] != '0) begin // RULE17
        nxt_st.report.valid = 1'b1;
        nxt_st.report.group = 1'b0;
        nxt_st.report.data = outputs_in[`IFO_RPT_W-1:0];
        nxt_st.reported[`IFO_RPT_W-1:0] = outputs_in[`IFO_RPT_W-1:0];
      end else if (diff[`IFO_NUM_OUT-1:`IFO_RPT_W] != '0) begin
        nxt_st.report.valid = 1'b1;
        nxt_st.report.group = 1'b1;
        nxt_st.report.data = outputs_in[`IFO_NUM_OUT-1:`IFO_RPT_W];
        nxt_st.reported[`IFO_NUM_OUT-1:`IFO_RPT_W] = outputs_in[`IFO_NUM_OUT-1:`IFO_RPT_W];
      end
    end

    // Read data stands only in the cycle after the strobe
    nxt_st.rdata = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `IFO_REG_TIMEOUT: nxt_st.rdata = `IFO_DATA_W'(st_ff.timeout_s);
        `IFO_REG_OVERRIDE: nxt_st.rdata = st_ff.ovr;
        `IFO_REG_STATUS: nxt_st.rdata = `IFO_DATA_W'({run_state_in, cfg_verified_in, st_ff.refused,
                                                       st_ff.end_cause, st_ff.phase});
        `IFO_REG_REMAIN: nxt_st.rdata = `IFO_DATA_W'(inact_remain);
        `IFO_REG_REAL_IN: nxt_st.rdata = `IFO_DATA_W'(real_in);
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff <= '0;
      st_ff.timeout_s <= `IFO_TIMEOUT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out = st_ff.rdata;
  assign logic_in_out = st_ff.logic_in;
  assign report_out = st_ff.report;
  assign real_in_out = real_in; // RULE6 RULE16
  assign gw_out_out = st_ff.gw_out;
  assign force_active_out = (st_ff.phase == IFO_PH_ACTIVE);
  assign outputs_zero_out = (st_ff.phase == IFO_PH_SHUTDOWN); // RULE13
  assign app_stop_out = (st_ff.phase == IFO_PH_SHUTDOWN); // RULE13
  assign config_verified_indicator_out = cfg_verified_in | st_ff.led; // RULE8
  assign host_cmd_out = st_ff.host_cmd;

endmodule : ifo_force_ctrl

//--- ifo_host_model.sv
// Purpose: Host software model on the register port
// Assumes: Strobes launched by non-blocking assignment after a rising edge
// Notes: Released address and data show the inverse of their last value
`timescale 1ns/1ps
`include "ifo_defs.svh"
module ifo_host_model (
  // Clock
  input wire logic ref_clk_in,
  // Register port
  output logic [`IFO_ADDR_W-1:0] reg_addr_out,
  output logic [`IFO_DATA_W-1:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [`IFO_DATA_W-1:0] reg_rdata_in,
  // Controller state
  output logic run_state_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 32'h0;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    run_state_out = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    @(negedge ref_clk_in);
    d = reg_rdata_in;
  endtask : rd_reg
  task automatic set_run(input logic v);
    @(posedge ref_clk_in);
    run_state_out <= v;
  endtask : set_run
  // One host only, so entry never races another client
  task automatic enter(input logic [15:0] t);
    set_run(1'b1);
    wr_reg(`IFO_REG_TIMEOUT, {16'h0000, t});
    wr_reg(`IFO_REG_CMD, 32'h1);
  endtask : enter
  // Warning window is 15 s, i.e. 30 half-second ticks
  task automatic ack_warning(output logic [31:0] r);
    rd_reg(`IFO_REG_REMAIN, r);
    if (r <= 32'h1e) wr_reg(`IFO_REG_CMD, 32'h4);
  endtask : ack_warning
endmodule : ifo_host_model

//--- ifo_force_ctrl_assertions.sv
// Purpose: Port checker of the force override block
// Assumes: One clock domain
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
`include "ifo_defs.svh"
module ifo_force_ctrl_assertions #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Inputs watched
  input wire logic reg_rd_in,
  input wire logic client_auth_in,
  input wire logic cfg_verified_in,
  input wire logic run_state_in,
  input wire logic [`IFO_NUM_IN-1:0] phys_in_in,
  input wire logic [`IFO_NUM_OUT-1:0] outputs_in,
  input wire logic logic_cycle_in,
  // Outputs watched
  input wire logic [`IFO_DATA_W-1:0] reg_rdata_out,
  input wire logic [`IFO_NUM_IN-1:0] logic_in_out,
  input wire ifo_pkg::ifo_report_s report_out,
  input wire logic [`IFO_NUM_IN-1:0] real_in_out,
  input wire logic [`IFO_NUM_OUT-1:0] gw_out_out,
  input wire logic force_active_out,
  input wire logic outputs_zero_out,
  input wire logic app_stop_out,
  input wire logic config_verified_indicator_out,
  input wire ifo_pkg::ifo_host_cmd_s host_cmd_out
);
  import ifo_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Sync plus filter needs four edges; five gives margin
  sequence s_pin_settle;
    $changed(phys_in_in) ##1 $stable(phys_in_in) [*5];
  endsequence
  sequence s_idle_run;
    !force_active_out && !$past(force_active_out) && !$past(force_active_out, 2) && $past(rst_n_in);
  endsequence
  property p_real_level; s_pin_settle |-> real_in_out == phys_in_in; endproperty
  property p_idle_real; s_idle_run |-> logic_in_out == $past(real_in_out); endproperty
  property p_end_zero; $fell(force_active_out) |-> outputs_zero_out && app_stop_out; endproperty
  property p_shut_hold; outputs_zero_out && run_state_in |=> outputs_zero_out && app_stop_out; endproperty
  property p_gw_zero; outputs_zero_out && $past(outputs_zero_out) |-> gw_out_out == '0; endproperty
  property p_gw_real;
    !outputs_zero_out && !$past(outputs_zero_out) && $past(rst_n_in) |-> gw_out_out == $past(outputs_in);
  endproperty
  property p_auth_refuse; !client_auth_in && !force_active_out |=> !force_active_out; endproperty
  property p_ver_refuse; cfg_verified_in && !force_active_out |=> !force_active_out; endproperty
  property p_ind_steady; cfg_verified_in && $past(cfg_verified_in) |-> config_verified_indicator_out; endproperty
  property p_cmd_blocked; force_active_out && $past(force_active_out) |-> host_cmd_out == '0; endproperty
  property p_rdata_idle; !$past(reg_rd_in) |-> reg_rdata_out == '0; endproperty
  property p_report_cause; report_out.valid |-> $past(logic_cycle_in); endproperty
  a_real_level: assert property (p_real_level) else $error("real level lags pin");
  a_idle_real: assert property (p_idle_real) else $error("idle input not real");
  a_end_zero: assert property (p_end_zero) else $error("end without zero outputs");
  a_shut_hold: assert property (p_shut_hold) else $error("shutdown left early");
  a_gw_zero: assert property (p_gw_zero) else $error("gateway not zero in shutdown");
  a_gw_real: assert property (p_gw_real) else $error("gateway not real outputs");
  a_auth_refuse: assert property (p_auth_refuse) else $error("entry without client");
  a_ver_refuse: assert property (p_ver_refuse) else $error("entry while verified");
  a_ind_steady: assert property (p_ind_steady) else $error("indicator not steady");
  a_cmd_blocked: assert property (p_cmd_blocked) else $error("command passed in force mode");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  a_report_cause: assert property (p_report_cause) else $error("report without cycle");
endmodule : ifo_force_ctrl_assertions

bind ifo_force_ctrl ifo_force_ctrl_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_rd_in(reg_rd_in), .client_auth_in(client_auth_in),
  .cfg_verified_in(cfg_verified_in), .run_state_in(run_state_in), .phys_in_in(phys_in_in),
  .outputs_in(outputs_in), .logic_cycle_in(logic_cycle_in), .reg_rdata_out(reg_rdata_out),
  .logic_in_out(logic_in_out), .report_out(report_out), .real_in_out(real_in_out), .gw_out_out(gw_out_out),
  .force_active_out(force_active_out), .outputs_zero_out(outputs_zero_out), .app_stop_out(app_stop_out),
  .config_verified_indicator_out(config_verified_indicator_out), .host_cmd_out(host_cmd_out));

//--- tb.sv
// Purpose: Self-checking bench of the force override block
// Assumes: Tick shortened to ten cycles
// Notes: Expected values come from the model function and counters
`timescale 1ns/1ps
`include "ifo_defs.svh"
module tb;
  import ifo_pkg::*;
  localparam int TICK = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, gw, r, ovr, outs;
  logic wr, rd, run, act, oz, astop, ind;
  logic auth = 1'b0;
  logic verified = 1'b0;
  logic lerr = 1'b0;
  logic lcyc = 1'b0;
  logic [15:0] phys = 16'h0;
  logic [15:0] lin, rin, last_lo, last_hi;
  ifo_report_s rpt;
  ifo_host_cmd_s hcmd;
  int n_fail = 0;
  int cmp_count = 0;
  int i, n;
  integer seed = 32'hd662;
  always #50 clk = ~clk;
  ifo_host_model host_u (.ref_clk_in(clk), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_rdata_in(rdata), .run_state_out(run));
  ifo_force_ctrl #(.TICK_CYCLES(TICK)) dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .client_auth_in(auth),
    .cfg_verified_in(verified), .run_state_in(run), .phys_in_in(phys), .link_error_in(lerr),
    .outputs_in(outs), .logic_cycle_in(lcyc), .logic_in_out(lin), .report_out(rpt), .real_in_out(rin),
    .gw_out_out(gw), .force_active_out(act), .outputs_zero_out(oz), .app_stop_out(astop),
    .config_verified_indicator_out(ind), .host_cmd_out(hcmd));
  function automatic logic [15:0] model_in(input logic [15:0] p, input logic [31:0] o);
    logic [15:0] m;
    m = p;
    for (int k = 0; k < 16; k++) begin
      if (o[2*k +: 2] == 2'b01) m[k] = 1'b0;
      if (o[2*k +: 2] == 2'b10) m[k] = 1'b1;
    end
    return m;
  endfunction : model_in
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // Only one group leaves per program cycle
  task automatic pulse_cycle;
    logic [17:0] e;
    @(posedge clk);
    lcyc <= 1'b1;
    e = '0;
    if (outs[15:0] != last_lo) e = {2'b10, outs[15:0]};
    else if (outs[31:16] != last_hi) e = {2'b11, outs[31:16]};
    if (e[17] && !e[16]) last_lo = outs[15:0];
    if (e[17] && e[16]) last_hi = outs[31:16];
    @(posedge clk);
    lcyc <= 1'b0;
    @(negedge clk);
    chk(32'(rpt), 32'(e));
  endtask : pulse_cycle
  task automatic wait_idle(input int lim, output int c);
    c = 0;
    while (act === 1'b1 && c < lim) begin
      @(negedge clk);
      c++;
    end
  endtask : wait_idle
  task automatic end_run;
    host_u.set_run(1'b0);
    repeat (3) @(negedge clk);
    chk(32'({oz, astop}), 32'h0);
  endtask : end_run
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    outs <= 32'h0;
    last_lo = 16'h0;
    last_hi = 16'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    host_u.rd_reg(`IFO_REG_TIMEOUT, r);
    chk(r, 32'h3c);
    host_u.rd_reg(8'h20, r);
    chk(r, 32'h0);
    chk(32'({act, oz, astop}), 32'h0);
    $display("test reset done");
    for (i = 0; i < 2; i++) begin
      auth <= (i == 1);
      verified <= (i == 1);
      host_u.enter(16'h2);
      @(negedge clk);
      chk(32'(act), 32'h0);
      host_u.rd_reg(`IFO_REG_STATUS, r);
      chk(32'(r[4]), 32'h1);
      host_u.wr_reg(`IFO_REG_STATUS, 32'hf0);
    end
    for (i = 3; i < 6; i++) begin
      host_u.wr_reg(`IFO_REG_CMD, 32'h1 << i);
      @(negedge clk);
      chk(32'(hcmd), 32'h4 >> (i - 3));
    end
    host_u.set_run(1'b0);
    $display("test refusal done");
    verified <= 1'b0;
    host_u.enter(16'h2);
    @(negedge clk);
    chk(32'(act), 32'h1);
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      phys <= 16'($random(seed));
      outs <= $random(seed);
      ovr = $random(seed);
      repeat (6) @(posedge clk);
      host_u.wr_reg(`IFO_REG_OVERRIDE, ovr);
      repeat (3) @(negedge clk);
      chk(32'(lin), 32'(model_in(phys, ovr)));
      chk(32'(rin), 32'(phys));
      chk(gw, outs);
      pulse_cycle();
      pulse_cycle();
    end
    for (i = 3; i < 6; i++) begin
      host_u.wr_reg(`IFO_REG_CMD, 32'h1 << i);
      @(negedge clk);
      chk(32'(hcmd), 32'h0);
    end
    host_u.rd_reg(`IFO_REG_STATUS, r);
    chk(32'({act, r[7:5]}), 32'hf);
    $display("test override done");
    repeat (5) @(posedge clk);
    host_u.ack_warning(r);
    wait_idle(200, n);
    chk(32'(n >= 30 && n <= 43), 32'h1);
    repeat (2) @(negedge clk);
    chk(32'({act, oz, astop}), 32'h3);
    chk(32'(lin), 32'(phys));
    host_u.rd_reg(`IFO_REG_STATUS, r);
    chk(32'(r[3:0]), 32'ha);
    end_run();
    $display("test timeout done");
    host_u.enter(16'h2);
    host_u.wr_reg(`IFO_REG_CMD, 32'h2);
    @(negedge clk);
    chk(32'({act, oz, astop}), 32'h3);
    host_u.rd_reg(`IFO_REG_STATUS, r);
    chk(32'(r[3:0]), 32'h6);
    end_run();
    $display("test exit done");
    host_u.enter(16'h3c);
    @(posedge clk);
    lerr <= 1'b1;
    wait_idle(900, n);
    chk(32'(n >= 585 && n <= 620), 32'h1);
    host_u.rd_reg(`IFO_REG_STATUS, r);
    chk(32'(r[3:0]), 32'he);
    lerr <= 1'b0;
    end_run();
    $display("test link error done");
    r = 32'(ind);
    repeat (10) @(negedge clk);
    chk(32'(ind != r[0]), 32'h1);
    verified <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'(ind), 32'h1);
    $display("test indicator done");
    give_verdict();
  end
endmodule : tb
